/* File: src/rss_pkg.sv */
//==============================================================
// rail strobe slot configuration constants
package rss_pkg;
	//==========================================================
	// register map
	localparam logic [7:0] ADDR_BACKUP = 8'h24;
	localparam logic [7:0] ADDR_SWREG  = 8'h25;
	localparam logic [7:0] ADDR_GPO    = 8'h26;
	localparam logic [7:0] RST_BACKUP  = 8'h00;
	localparam logic [7:0] RST_SWREG   = 8'h73;
	localparam logic [7:0] RST_GPO     = 8'h03;
	localparam logic [7:0] MASK_BACKUP = 8'h33;
	//==========================================================
	// strobe numbering
	localparam logic [3:0] STROBE_FIRST  = 4'h1;
	localparam logic [3:0] STROBE_SEALED = 4'h3;
	localparam logic [3:0] STROBE_LAST   = 4'ha;
	localparam logic [3:0] BK_CODE_LO    = 4'h1;
	localparam logic [3:0] BK_CODE_HI    = 4'h2;
	localparam logic [3:0] WIDE_CODE_LO  = 4'h3;
	localparam logic [3:0] WIDE_CODE_HI  = 4'ha;
	//==========================================================
	// rail indices
	localparam int RAILS     = 6;
	localparam int RAIL_BK_A = 0;
	localparam int RAIL_BK_B = 1;
	localparam int RAIL_SW   = 2;
	localparam int RAIL_LDO  = 3;
	localparam int RAIL_GP_A = 4;
	localparam int RAIL_GP_C = 5;
	//==========================================================
	// strobe dwell time
	localparam int CLK_MHZ       = 100;
	localparam int STROBE_GAP_NS = 100;
	localparam int STROBE_GAP_CYC = (STROBE_GAP_NS * CLK_MHZ + 999) / 1000;
	//==========================================================
	// types
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rss_req_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} rss_state_t;
endpackage : rss_pkg

/* File: src/rss_top.sv */
//==============================================================
// Function
// RULE1 - the second backup converter slot lives in bits 5:4 of the backup slot register, read/write.
// RULE2 - the first backup converter slot lives in bits 1:0 of the backup slot register, read/write.
// RULE3 - a backup slot code of 1 enables at strobe 1, 2 at strobe 2, and 0 or 3 leaves the rail alone.
// RULE4 - strobes 1 and 2 run only while the freshness seal flag is 0, otherwise they are skipped.
// RULE5 - once the seal is broken the sequencer never turns off either backup converter.
// RULE6 - a 4-bit slot code 3h..Ah enables at strobes 3..10, any other code leaves the rail alone.
// RULE7 - the switch/regulator register holds switch slot in 7:4 and regulator slot in 3:0, reset 0x73.
// RULE8 - the general output register holds output c slot in 7:4 and output a slot in 3:0, reset 0x03.
// RULE9 - the backup register resets to 0x00 and its bits 7:6 and 3:2 always read zero.
// RULE10 - a write lands only after a valid unlock, and each unlock admits one write.
// RULE11 - power-up steps through strobes in ascending order enabling each rail named by the strobe.
`timescale 1ns/1ps
`default_nettype none
module rss_top #(
	parameter int GAP_CYC = rss_pkg::STROBE_GAP_CYC
) (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	// register access
	input  wire rss_pkg::rss_req_t req,
	input  wire logic              unlock_ok,
	output logic [7:0]             rdata_ff,
	output logic                   unlocked_ff,
	// sequencer control
	input  wire logic              freshness_seal_flag,
	input  wire logic              seq_start,
	input  wire logic              seq_off,
	output logic                   busy,
	output logic [3:0]             strobe_ff,
	output logic [5:0]             rail_en_ff
);
	//==========================================================
	// register file
	logic [7:0] backup_ff;
	logic [7:0] swreg_ff;
	logic [7:0] gpo_ff;
	wire        wr_ok   = req.wr & unlocked_ff;
	wire        wr_bk   = wr_ok & (req.addr == rss_pkg::ADDR_BACKUP);
	wire        wr_sw   = wr_ok & (req.addr == rss_pkg::ADDR_SWREG);
	wire        wr_gp   = wr_ok & (req.addr == rss_pkg::ADDR_GPO);
	wire [7:0]  rd_mux  = (req.addr == rss_pkg::ADDR_BACKUP) ? backup_ff :
		(req.addr == rss_pkg::ADDR_SWREG) ? swreg_ff :
		(req.addr == rss_pkg::ADDR_GPO) ? gpo_ff : 8'h00;
	wire        nxt_unlocked = unlock_ok | (unlocked_ff & ~req.wr);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			backup_ff   <= rss_pkg::RST_BACKUP; // RULE9
			swreg_ff    <= rss_pkg::RST_SWREG; // RULE7
			gpo_ff      <= rss_pkg::RST_GPO; // RULE8
			unlocked_ff <= 1'b0;
			rdata_ff    <= 8'h00;
		end else begin
			if (wr_bk) begin
				backup_ff <= req.wdata & rss_pkg::MASK_BACKUP; // RULE1 RULE2 RULE9
			end
			if (wr_sw) begin
				swreg_ff <= req.wdata; // RULE7
			end
			if (wr_gp) begin
				gpo_ff <= req.wdata; // RULE8
			end
			unlocked_ff <= nxt_unlocked; // RULE10
			if (req.rd) begin
				rdata_ff <= rd_mux;
			end
		end
	end

	//==========================================================
	// slot decode per rail
	wire [3:0] slot [rss_pkg::RAILS];
	wire [5:0] hit;
	assign slot[rss_pkg::RAIL_BK_A] = {2'b00, backup_ff[1:0]};
	assign slot[rss_pkg::RAIL_BK_B] = {2'b00, backup_ff[5:4]};
	assign slot[rss_pkg::RAIL_SW]   = swreg_ff[7:4];
	assign slot[rss_pkg::RAIL_LDO]  = swreg_ff[3:0];
	assign slot[rss_pkg::RAIL_GP_A] = gpo_ff[3:0];
	assign slot[rss_pkg::RAIL_GP_C] = gpo_ff[7:4];

	genvar gi;
	generate
		for (gi = 0; gi < rss_pkg::RAILS; gi++) begin : g_rail
			localparam logic [3:0] LO = (gi < 2) ? rss_pkg::BK_CODE_LO :
				rss_pkg::WIDE_CODE_LO;
			localparam logic [3:0] HI = (gi < 2) ? rss_pkg::BK_CODE_HI :
				rss_pkg::WIDE_CODE_HI;
			assign hit[gi] = (slot[gi] >= LO) && (slot[gi] <= HI) &&
				(slot[gi] == strobe_ff); // RULE3 RULE6
		end
	endgenerate

	//==========================================================
	// strobe sequencer
	rss_pkg::rss_state_t state_ff;
	rss_pkg::rss_state_t nxt_state;
	logic [15:0] dwell_ff;
	logic [3:0]  nxt_strobe;
	logic [15:0] nxt_dwell;
	logic [5:0]  nxt_rail;
	wire         step_end = (dwell_ff == 16'h0000);
	wire         last     = (strobe_ff == rss_pkg::STROBE_LAST);
	wire [3:0]   start_strobe = freshness_seal_flag ?
		rss_pkg::STROBE_SEALED : rss_pkg::STROBE_FIRST; // RULE4
	wire [5:0]   keep_mask = freshness_seal_flag ? 6'h03 : 6'h00; // RULE5
	assign busy = (state_ff == rss_pkg::ST_RUN);

	always_comb begin
		nxt_state  = state_ff;
		nxt_strobe = strobe_ff;
		nxt_dwell  = dwell_ff;
		nxt_rail   = rail_en_ff;
		case (state_ff)
			rss_pkg::ST_IDLE: begin
				if (seq_start) begin
					nxt_state  = rss_pkg::ST_RUN;
					nxt_strobe = start_strobe; // RULE4
					nxt_dwell  = 16'(GAP_CYC - 1);
				end else if (seq_off) begin
					nxt_rail = rail_en_ff & keep_mask; // RULE5
				end
			end
			rss_pkg::ST_RUN: begin
				nxt_rail = rail_en_ff | hit; // RULE11
				if (!step_end) begin
					nxt_dwell = dwell_ff - 16'h0001;
				end else if (last) begin
					nxt_state  = rss_pkg::ST_IDLE;
					nxt_strobe = 4'h0;
				end else begin
					nxt_strobe = strobe_ff + 4'h1; // RULE11
					nxt_dwell  = 16'(GAP_CYC - 1);
				end
			end
			default: begin
				nxt_state = rss_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_ff   <= rss_pkg::ST_IDLE;
			strobe_ff  <= 4'h0;
			dwell_ff   <= 16'h0000;
			rail_en_ff <= 6'h00;
		end else begin
			state_ff   <= nxt_state;
			strobe_ff  <= nxt_strobe;
			dwell_ff   <= nxt_dwell;
			rail_en_ff <= nxt_rail;
		end
	end

	//==========================================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence s_wr(logic [7:0] a);
		req.wr && unlocked_ff && req.addr == a;
	endsequence
	sequence s_run_at(logic [3:0] s);
		busy && strobe_ff == s;
	endsequence

	AST_BK_B_FIELD: assert property (s_wr(rss_pkg::ADDR_BACKUP) |=> // RULE1
		backup_ff[5:4] == $past(req.wdata[5:4]))
		else $error("backup b slot not stored");
	AST_BK_A_FIELD: assert property (s_wr(rss_pkg::ADDR_BACKUP) |=> // RULE2
		backup_ff[1:0] == $past(req.wdata[1:0]))
		else $error("backup a slot not stored");
	AST_BK_DECODE: assert property (s_run_at(4'h2) ##0 // RULE3
		(backup_ff[5:4] == 2'h2) |=> rail_en_ff[rss_pkg::RAIL_BK_B])
		else $error("backup b not enabled at strobe 2");
	AST_SEAL_SKIP: assert property (!busy && seq_start && // RULE4
		freshness_seal_flag |=> strobe_ff == 4'h3)
		else $error("sealed run did not skip strobes 1 and 2");
	AST_SEAL_KEEP: assert property (freshness_seal_flag |=> // RULE5
		(rail_en_ff[1:0] & $past(rail_en_ff[1:0])) ==
		$past(rail_en_ff[1:0]))
		else $error("backup converter turned off after seal");
	AST_WIDE_DECODE: assert property (busy && // RULE6
		swreg_ff[7:4] >= rss_pkg::WIDE_CODE_LO &&
		swreg_ff[7:4] == strobe_ff |=> rail_en_ff[rss_pkg::RAIL_SW])
		else $error("switch not enabled at its strobe");
	AST_SW_FIELD: assert property (s_wr(rss_pkg::ADDR_SWREG) |=> // RULE7
		swreg_ff == $past(req.wdata))
		else $error("switch/regulator register not stored");
	AST_GP_FIELD: assert property (s_wr(rss_pkg::ADDR_GPO) |=> // RULE8
		gpo_ff == $past(req.wdata))
		else $error("general output register not stored");
	AST_RSV_ZERO: assert property (req.rd && // RULE9
		req.addr == rss_pkg::ADDR_BACKUP |=> (rdata_ff & 8'hcc) == 8'h00)
		else $error("reserved backup bits read non-zero");
	AST_LOCKED: assert property (req.wr && !unlocked_ff |=> // RULE10
		$stable(backup_ff) && $stable(swreg_ff) && $stable(gpo_ff))
		else $error("write landed without unlock");
	AST_ASCEND: assert property (busy && $changed(strobe_ff) && // RULE11
		$past(busy) |-> strobe_ff == $past(strobe_ff) + 4'h1)
		else $error("strobe did not ascend by one");
endmodule : rss_top
`default_nettype wire

/* File: sim/rss_host.sv */
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// host side register access model
module rss_host (
	// clock
	input  wire logic              sys_clk,
	// register access
	output var rss_pkg::rss_req_t  req,
	output var logic               unlock_ok,
	input  wire logic [7:0]        rdata_ff
);
	initial begin
		req = '0;
		unlock_ok = 1'b0;
	end
	// unlock then one write; unl low sends a write with no unlock
	task automatic write(input logic [7:0] a, input logic [7:0] d,
		input logic unl);
		if (unl) begin
			@(posedge sys_clk) unlock_ok <= 1'b1;
		end
		@(posedge sys_clk);
		unlock_ok <= 1'b0;
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk);
		req <= '0;
	endtask : write
	// unlock pulse on its own, arming the next write
	task automatic arm();
		@(posedge sys_clk);
		unlock_ok <= 1'b1;
		@(posedge sys_clk);
		unlock_ok <= 1'b0;
	endtask : arm
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge sys_clk);
		req <= '0;
		@(negedge sys_clk);
		d = rdata_ff;
	endtask : read
endmodule : rss_host
`default_nettype wire

/* File: sim/rss_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// bench top
module rss_top_bench;
	logic              sys_clk;
	logic              resetn;
	rss_pkg::rss_req_t req;
	logic              unlock_ok;
	logic [7:0]        rdata_ff;
	logic              unlocked_ff;
	logic              freshness_seal_flag;
	logic              seq_start;
	logic              seq_off;
	logic              busy;
	logic [5:0]        rail_en_ff;
	logic [3:0]        strobe_ff;
	int                n_fail;
	int                num_checks;
	rss_top #(.GAP_CYC(1)) dut (.sys_clk(sys_clk), .resetn(resetn),
		.req(req), .unlock_ok(unlock_ok), .rdata_ff(rdata_ff),
		.unlocked_ff(unlocked_ff),
		.freshness_seal_flag(freshness_seal_flag),
		.seq_start(seq_start), .seq_off(seq_off), .busy(busy),
		.strobe_ff(strobe_ff), .rail_en_ff(rail_en_ff));
	rss_host host (.sys_clk(sys_clk), .req(req),
		.unlock_ok(unlock_ok), .rdata_ff(rdata_ff));
	//==========================================================
	// clock and watchdog
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		n_fail++;
		complete_run();
	end
	//==========================================================
	// helpers
	task automatic check(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.read(a, d);
		check("rdata", d, exp);
	endtask : rd_chk
	task automatic run_seq(input logic seal, input logic [7:0] rail,
		input int cyc);
		int n;
		logic [3:0] st;
		n = 0;
		st = seal ? rss_pkg::STROBE_SEALED : rss_pkg::STROBE_FIRST;
		@(posedge sys_clk);
		freshness_seal_flag <= seal;
		seq_start <= 1'b1;
		@(posedge sys_clk);
		seq_start <= 1'b0;
		@(negedge sys_clk);
		while (busy === 1'b1 && n < 50) begin
			check("strobe", {4'h0, strobe_ff}, {4'h0, st} + 8'(n));
			n++;
			@(negedge sys_clk);
		end
		check("strobe_idle", {4'h0, strobe_ff}, 8'h00);
		@(negedge sys_clk);
		check("busy_cycles", 8'(n), 8'(cyc));
		check("rail_en", {2'h0, rail_en_ff}, rail);
	endtask : run_seq
	task automatic off(input logic seal, input logic [7:0] rail);
		@(posedge sys_clk);
		freshness_seal_flag <= seal;
		seq_off <= 1'b1;
		@(posedge sys_clk);
		seq_off <= 1'b0;
		@(negedge sys_clk);
		check("rail_off", {2'h0, rail_en_ff}, rail);
	endtask : off
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	//==========================================================
	// tests
	initial begin
		n_fail = 0;
		num_checks = 0;
		resetn = 1'b0;
		freshness_seal_flag = 1'b0;
		seq_start = 1'b0;
		seq_off = 1'b0;
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		rd_chk(8'h24, 8'h00);
		rd_chk(8'h25, 8'h73);
		rd_chk(8'h26, 8'h03);
		host.write(8'h25, 8'h5a, 1'b0);
		rd_chk(8'h25, 8'h73);
		host.write(8'h24, 8'hff, 1'b1);
		rd_chk(8'h24, 8'h33);
		host.write(8'h24, 8'h21, 1'b1);
		host.write(8'h25, 8'h3a, 1'b1);
		host.write(8'h26, 8'hb5, 1'b1);
		rd_chk(8'h25, 8'h3a);
		rd_chk(8'h26, 8'hb5);
		rd_chk(8'h30, 8'h00);
		host.arm();
		@(negedge sys_clk);
		check("unlocked", {7'h00, unlocked_ff}, 8'h01);
		host.write(8'h30, 8'hff, 1'b0);
		@(negedge sys_clk);
		check("unlocked", {7'h00, unlocked_ff}, 8'h00);
		host.write(8'h26, 8'h00, 1'b0);
		rd_chk(8'h26, 8'hb5);
		run_seq(1'b0, 8'h1f, 10);
		off(1'b1, 8'h03);
		off(1'b0, 8'h00);
		run_seq(1'b1, 8'h1c, 8);
		off(1'b0, 8'h00);
		host.write(8'h24, 8'h30, 1'b1);
		run_seq(1'b0, 8'h1c, 10);
		// reset again while a sequence has just started
		@(posedge sys_clk);
		seq_start <= 1'b1;
		@(posedge sys_clk);
		seq_start <= 1'b0;
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		@(negedge sys_clk);
		check("busy_rst", {7'h00, busy}, 8'h00);
		check("strobe_rst", {4'h0, strobe_ff}, 8'h00);
		check("rail_rst", {2'h0, rail_en_ff}, 8'h00);
		check("unlocked_rst", {7'h00, unlocked_ff}, 8'h00);
		check("rdata_rst", rdata_ff, 8'h00);
		rd_chk(8'h24, 8'h00);
		rd_chk(8'h25, 8'h73);
		rd_chk(8'h26, 8'h03);
		complete_run();
	end
endmodule : rss_top_bench
`default_nettype wire
